/* File: logic/rct_pkg.sv */
package rct_pkg;

  // Number of timer instances and width of each counter.
  localparam int unsigned NUM_TIMERS = 3;
  localparam int unsigned CNT_WIDTH  = 16;

  // Register offsets, identical in every page.
  localparam logic [7:0] OFS_TIMER_CONTROL       = 8'hC8;
  localparam logic [7:0] OFS_TIMER_CONFIGURATION = 8'hC9;
  localparam logic [7:0] OFS_RELOAD_CAPTURE_LOW  = 8'hCA;
  localparam logic [7:0] OFS_RELOAD_CAPTURE_HIGH = 8'hCB;
  localparam logic [7:0] OFS_COUNTER_LOW_BYTE    = 8'hCC;
  localparam logic [7:0] OFS_COUNTER_HIGH_BYTE   = 8'hCD;

  // Register page of the first instance; instance n sits on page base plus n.
  localparam logic [7:0] PAGE_BASE = 8'h00;

  // Field positions in timer_control.
  localparam int unsigned CTL_OVERFLOW_FLAG       = 7;
  localparam int unsigned CTL_EXTERNAL_EVENT_FLAG = 6;
  localparam int unsigned CTL_EXTERNAL_INPUT_EN   = 3;
  localparam int unsigned CTL_RUN_CONTROL         = 2;
  localparam int unsigned CTL_COUNTER_SELECT      = 1;
  localparam int unsigned CTL_CAPTURE_SELECT      = 0;

  // Field positions in timer_configuration.
  localparam int unsigned CFG_CLOCK_SELECT_HIGH   = 4;
  localparam int unsigned CFG_CLOCK_SELECT_LOW    = 3;
  localparam int unsigned CFG_TOGGLE_STATE        = 2;
  localparam int unsigned CFG_TOGGLE_OUTPUT_EN    = 1;
  localparam int unsigned CFG_DOWN_COUNT_EN       = 0;

  // Writable bits; reserved bits read as zero.
  localparam logic [7:0] CTL_WRITE_MASK    = 8'hCF;
  localparam logic [7:0] CFG_WRITE_MASK    = 8'h1F;
  localparam logic [7:0] CFG_TOGGLE_BITS   = 8'h06;

  // Reset values and counter end points.
  localparam logic [7:0]  CTL_RESET   = 8'h00;
  localparam logic [7:0]  CFG_RESET   = 8'h00;
  localparam logic [15:0] RCAP_RESET  = 16'h0000;
  localparam logic [15:0] CNT_RESET   = 16'h0000;
  localparam logic [15:0] CNT_ALL_ONE = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO    = 16'h0000;
  localparam logic [7:0]  READ_IDLE   = 8'h00;

  // Timer clock choices.
  typedef enum logic [1:0] {
    CLK_SYS_DIV12 = 2'b00,
    CLK_SYS       = 2'b01,
    CLK_EXT_DIV8  = 2'b10,
    CLK_SYS_DIV2  = 2'b11
  } rct_clksel_type;

  // Prescaler defaults.
  localparam int unsigned DIV_SLOW_DEFAULT = 12;
  localparam int unsigned DIV_FAST_DEFAULT = 2;
  localparam int unsigned DIV_EXT_DEFAULT  = 8;

endpackage

/* File: logic/rct_tick_if.sv */
`timescale 1ns/1ns
// Timebase ticks and synchronised pin levels passed to the timer channels.
interface rct_tick_if;
  logic       tick_div12;  // One-cycle pulse every twelfth system clock.
  logic       tick_div2;   // One-cycle pulse every second system clock.
  logic       tick_ext8;   // One-cycle pulse every eighth external clock rise.
  logic [1:0] count_level; // Synchronised count pins: 0 shared, 1 third.
  logic [1:0] gate_level;  // Synchronised gate pins: 0 shared, 1 third.
  modport source (output tick_div12, output tick_div2, output tick_ext8,
                  output count_level, output gate_level);
  modport sink   (input tick_div12, input tick_div2, input tick_ext8,
                  input count_level, input gate_level);
endinterface

/* File: logic/rct_timebase.sv */
`timescale 1ns/1ns
// Prescalers and pin synchronisers shared by all timer instances.
module rct_timebase #(
  parameter int unsigned DIV_SLOW = rct_pkg::DIV_SLOW_DEFAULT,
  parameter int unsigned DIV_FAST = rct_pkg::DIV_FAST_DEFAULT,
  parameter int unsigned DIV_EXT  = rct_pkg::DIV_EXT_DEFAULT
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ext_clock,
  input  wire logic [1:0] count_pins,
  input  wire logic [1:0] gate_pins,
  rct_tick_if.source  ticks
);
  import rct_pkg::*;

  // The counters below are four bits wide, so larger divisors cannot be served.
  if (DIV_SLOW < 2 || DIV_SLOW > 16 || DIV_FAST < 2 || DIV_FAST > 16 || DIV_EXT < 2 || DIV_EXT > 16) begin
    $error("rct_timebase: divisors must lie between 2 and 16");
  end

  localparam logic [3:0] SLOW_LAST = 4'(DIV_SLOW - 1);
  localparam logic [3:0] FAST_LAST = 4'(DIV_FAST - 1);
  localparam logic [3:0] EXT_LAST  = 4'(DIV_EXT - 1);

  // Whole state of the timebase.
  typedef struct packed {
    logic [3:0] slow_cnt; // Divide-by-twelve counter.
    logic [3:0] fast_cnt; // Divide-by-two counter.
    logic [3:0] ext_cnt;  // Counts synchronised external clock rises.
    logic [2:0] ext_sync; // Two synchroniser stages plus previous level.
    logic [3:0] pin_s1;   // First synchroniser stage of the pins.
    logic [3:0] pin_s2;   // Second synchroniser stage of the pins.
    logic       t12;      // Registered ticks.
    logic       t2;
    logic       t8;
  } rct_tb_type;

  rct_tb_type state_reg;
  rct_tb_type state_next;

  // Next-state logic: prescalers run freely; the external clock is only
  // looked at after two flops, which limits it to below half the system clock.
  always_comb begin
    state_next = state_reg;
    state_next.t12 = 1'b0;
    state_next.t2 = 1'b0;
    state_next.t8 = 1'b0;
    if (state_reg.slow_cnt == SLOW_LAST) begin
      state_next.slow_cnt = '0;
      state_next.t12 = 1'b1;
    end else begin
      state_next.slow_cnt = state_reg.slow_cnt + 4'h1;
    end
    if (state_reg.fast_cnt == FAST_LAST) begin
      state_next.fast_cnt = '0;
      state_next.t2 = 1'b1;
    end else begin
      state_next.fast_cnt = state_reg.fast_cnt + 4'h1;
    end
    // Stage 0 feeds stage 1 only; stage 1 and the previous level form the edge.
    state_next.ext_sync = {state_reg.ext_sync[1], state_reg.ext_sync[0], ext_clock};
    if (state_reg.ext_sync[1] && !state_reg.ext_sync[2]) begin
      if (state_reg.ext_cnt == EXT_LAST) begin
        state_next.ext_cnt = '0;
        state_next.t8 = 1'b1;
      end else begin
        state_next.ext_cnt = state_reg.ext_cnt + 4'h1;
      end
    end
    state_next.pin_s1 = {gate_pins, count_pins};
    state_next.pin_s2 = state_reg.pin_s1;
  end

  // State register.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign ticks.tick_div12  = state_reg.t12;
  assign ticks.tick_div2   = state_reg.t2;
  assign ticks.tick_ext8   = state_reg.t8;
  assign ticks.count_level = state_reg.pin_s2[1:0];
  assign ticks.gate_level  = state_reg.pin_s2[3:2];

endmodule

/* File: logic/rct_timer_top.sv */
`timescale 1ns/1ns
module rct_timer_top (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] sfr_page,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr_en,
  input  wire logic       sfr_rd_en,
  output logic      [7:0] sfr_rdata,
  input  wire logic       ext_clock,
  input  wire logic       shared_count_pin,
  input  wire logic       third_count_pin,
  input  wire logic       shared_gate_pin,
  input  wire logic       third_gate_pin,
  output logic            first_toggle_out,
  output logic            first_toggle_oe,
  output logic            third_toggle_out,
  output logic            third_toggle_oe
);
  import rct_pkg::*;

  // Registers and edge history of one timer instance.
  typedef struct packed {
    logic [7:0]  ctrl;       // timer_control.
    logic [7:0]  cfg;        // timer_configuration.
    logic [15:0] rcap;       // reload_capture_high:reload_capture_low.
    logic [15:0] cnt;        // counter_high_byte:counter_low_byte.
    logic        gate_prev;  // Gate level one cycle ago, for falling edges.
    logic        count_prev; // Count pin level one cycle ago.
  } rct_chan_type;

  // Whole state of the block.
  typedef struct packed {
    rct_chan_type [NUM_TIMERS-1:0] chan;  // Per-instance state.
    logic [7:0]                    rdata; // Registered read data.
  } rct_state_type;

  rct_state_type state_reg;
  rct_state_type state_next;
  rct_chan_type  chan_next [NUM_TIMERS];
  logic [7:0]    read_byte [NUM_TIMERS];

  rct_tick_if ticks ();

  // Shared prescalers and synchronisers; pins reach the channels only after two flops.
  rct_timebase #(
    .DIV_SLOW (DIV_SLOW_DEFAULT),
    .DIV_FAST (DIV_FAST_DEFAULT),
    .DIV_EXT  (DIV_EXT_DEFAULT)
  ) u_timebase (
    .clk        (clk),
    .reset      (reset),
    .ext_clock  (ext_clock),
    .count_pins ({third_count_pin, shared_count_pin}),
    .gate_pins  ({third_gate_pin, shared_gate_pin}),
    .ticks      (ticks)
  );

  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_chan
    // Pin set used by this instance: the third has its own pins.
    localparam int unsigned PIN =
      (i == NUM_TIMERS - 1) ? 1 : 0;
    // The middle instance has no toggle output, so its toggle bits stay zero.
    localparam bit HAS_TOGGLE = (i != 1);
    localparam logic [7:0] PAGE = PAGE_BASE + 8'(i);
    localparam logic [7:0] CFG_MASK = HAS_TOGGLE ? CFG_WRITE_MASK :
                                      (CFG_WRITE_MASK & ~CFG_TOGGLE_BITS);

    logic           sel;       // This instance's page is selected.
    logic           wr;        // Any write to this page.
    logic           wr_ctl;    // Writes to each register of this instance.
    logic           wr_cfg;
    logic           wr_rcl;
    logic           wr_rch;
    logic           wr_cl;
    logic           wr_ch;

    logic           gate_lvl;  // Synchronised gate level.
    logic           cnt_lvl;   // Synchronised count pin level.
    logic           tclk;      // Selected internal timer clock tick.
    logic           tick;      // Counter advances this cycle.
    logic           down;      // Count direction is downward.
    logic           gate_fall; // Enabled gate falling edge.

    logic           ovf;       // Overflow or underflow this cycle.
    logic           set_tf;    // Hardware set of the overflow flag.
    logic           set_exf;   // Hardware set of the external flag.
    logic           tog_exf;   // Reload-mode toggle of the external flag.
    rct_chan_type   c;         // Working copy of this instance.
    rct_clksel_type csel;      // Clock select field.

    // Register decode for this page.
    assign sel    = (sfr_page == PAGE);
    assign wr     = sel && sfr_wr_en;
    assign wr_ctl = wr && (sfr_addr == OFS_TIMER_CONTROL);
    assign wr_cfg = wr && (sfr_addr == OFS_TIMER_CONFIGURATION);
    assign wr_rcl = wr && (sfr_addr == OFS_RELOAD_CAPTURE_LOW);
    assign wr_rch = wr && (sfr_addr == OFS_RELOAD_CAPTURE_HIGH);
    assign wr_cl  = wr && (sfr_addr == OFS_COUNTER_LOW_BYTE);
    assign wr_ch  = wr && (sfr_addr == OFS_COUNTER_HIGH_BYTE);

    // Counting, capture, reload, flags and toggle for one instance.
    always_comb begin
      c = state_reg.chan[i];

      gate_lvl = ticks.gate_level[PIN];
      cnt_lvl = ticks.count_level[PIN];

      csel = rct_clksel_type'(c.cfg[CFG_CLOCK_SELECT_HIGH:CFG_CLOCK_SELECT_LOW]);

      // Timer clock choice.
      case (csel)
        CLK_SYS_DIV12: tclk = ticks.tick_div12;
        CLK_SYS:       tclk = 1'b1;
        CLK_EXT_DIV8:  tclk = ticks.tick_ext8;
        CLK_SYS_DIV2:  tclk = ticks.tick_div2;
        default:       tclk = 1'b0;
      endcase

      // Counter function uses high-to-low transitions of the count pin instead.
      tick = c.ctrl[CTL_RUN_CONTROL] &&
             (c.ctrl[CTL_COUNTER_SELECT] ? (c.count_prev && !cnt_lvl) : tclk);

      // Direction is up unless down-count is enabled and the gate is low.
      down = c.cfg[CFG_DOWN_COUNT_EN] && !gate_lvl;

      // With down-count enabled the gate only steers direction.
      gate_fall = c.gate_prev && !gate_lvl &&
                  c.ctrl[CTL_EXTERNAL_INPUT_EN] && !c.cfg[CFG_DOWN_COUNT_EN];
      ovf = 1'b0;
      set_exf = 1'b0;

      if (tick) begin
        if (c.ctrl[CTL_CAPTURE_SELECT]) begin
          // Capture mode wraps freely in both directions.
          if (down) begin
            ovf = (c.cnt == CNT_ZERO);
            c.cnt = c.cnt - 16'h0001;
          end else begin
            ovf = (c.cnt == CNT_ALL_ONE);
            c.cnt = c.cnt + 16'h0001;
          end
        end else if (down) begin
          if (c.cnt == c.rcap) begin
            ovf = 1'b1;
            c.cnt = CNT_ALL_ONE;
          end else begin
            c.cnt = c.cnt - 16'h0001;
          end
        end else if (c.cnt == CNT_ALL_ONE) begin
          ovf = 1'b1;
          c.cnt = c.rcap;
        end else begin
          c.cnt = c.cnt + 16'h0001;
        end
      end

      // An enabled gate edge reload outranks a counter step in the same cycle; a capture takes the count from before the step.
      if (gate_fall) begin
        set_exf = 1'b1;
        if (c.ctrl[CTL_CAPTURE_SELECT]) begin
          c.rcap = state_reg.chan[i].cnt;
        end else begin
          c.cnt = c.rcap;
        end
      end

      set_tf = ovf;
      tog_exf = ovf && !c.ctrl[CTL_CAPTURE_SELECT];
      if (tog_exf) begin
        c.ctrl[CTL_EXTERNAL_EVENT_FLAG] = !c.ctrl[CTL_EXTERNAL_EVENT_FLAG];
      end

      // Half a period per overflow gives an equal high and low time.
      if (ovf && HAS_TOGGLE) begin
        c.cfg[CFG_TOGGLE_STATE] = !c.cfg[CFG_TOGGLE_STATE];
      end

      // Software writes; a counter or reload write beats the hardware update.
      if (wr_ctl) begin
        c.ctrl = sfr_wdata & CTL_WRITE_MASK;
      end
      if (wr_cfg) begin
        // Writing the toggle state forces the output level directly.
        c.cfg = sfr_wdata & CFG_MASK;
      end

      if (wr_rcl) begin
        c.rcap[7:0] = sfr_wdata;
      end
      if (wr_rch) begin
        c.rcap[15:8] = sfr_wdata;
      end

      if (wr_cl) begin
        c.cnt[7:0] = sfr_wdata;
      end
      if (wr_ch) begin
        c.cnt[15:8] = sfr_wdata;
      end

      // Hardware sets are applied last so a simultaneous clear cannot lose them.
      if (set_tf) begin
        c.ctrl[CTL_OVERFLOW_FLAG] = 1'b1;
      end
      if (set_exf) begin
        c.ctrl[CTL_EXTERNAL_EVENT_FLAG] = 1'b1;
      end

      c.gate_prev = gate_lvl;
      c.count_prev = cnt_lvl;

      chan_next[i] = c;
    end

    // Read data of this instance for the shared read mux.
    always_comb begin
      case (sfr_addr)
        OFS_TIMER_CONTROL:       read_byte[i] = state_reg.chan[i].ctrl;
        OFS_TIMER_CONFIGURATION: read_byte[i] = state_reg.chan[i].cfg;
        OFS_RELOAD_CAPTURE_LOW:  read_byte[i] = state_reg.chan[i].rcap[7:0];
        OFS_RELOAD_CAPTURE_HIGH: read_byte[i] = state_reg.chan[i].rcap[15:8];
        OFS_COUNTER_LOW_BYTE:    read_byte[i] = state_reg.chan[i].cnt[7:0];
        OFS_COUNTER_HIGH_BYTE:   read_byte[i] = state_reg.chan[i].cnt[15:8];
        default:                 read_byte[i] = READ_IDLE;
      endcase
    end
  end

  // Assemble the next state and the registered read data.
  always_comb begin
    state_next = state_reg;

    for (int k = 0; k < NUM_TIMERS; k++) begin
      state_next.chan[k] = chan_next[k];
    end

    // Unmapped pages and offsets read as zero; data appears one cycle later.
    state_next.rdata = READ_IDLE;

    if (sfr_rd_en) begin
      for (int k = 0; k < NUM_TIMERS; k++) begin
        if (sfr_page == PAGE_BASE + 8'(k)) begin
          state_next.rdata = read_byte[k];
        end
      end
    end
  end

  // State register with synchronous reset to the documented values.
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int k = 0; k < NUM_TIMERS; k++) begin
        state_reg.chan[k].ctrl       <= CTL_RESET;
        state_reg.chan[k].cfg        <= CFG_RESET;
        state_reg.chan[k].rcap       <= RCAP_RESET;
        state_reg.chan[k].cnt        <= CNT_RESET;
        state_reg.chan[k].gate_prev  <= 1'b0;
        state_reg.chan[k].count_prev <= 1'b0;
      end

      state_reg.rdata <= READ_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from flops; toggle levels are always driven, with each enable as a separate output.
  assign sfr_rdata        = state_reg.rdata;
  assign first_toggle_out = state_reg.chan[0].cfg[CFG_TOGGLE_STATE];
  assign first_toggle_oe  = state_reg.chan[0].cfg[CFG_TOGGLE_OUTPUT_EN];

  assign third_toggle_out = state_reg.chan[NUM_TIMERS-1].cfg[CFG_TOGGLE_STATE];
  assign third_toggle_oe  = state_reg.chan[NUM_TIMERS-1].cfg[CFG_TOGGLE_OUTPUT_EN];

endmodule

/* File: bench/rct_timer_top_asserts.sv */
`timescale 1ns/1ns
// Bus and toggle checks on the block's ports.
module rct_timer_top_asserts (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_wr_en,
  input wire logic       sfr_rd_en,
  input wire logic [7:0] sfr_rdata,
  input wire logic       first_toggle_out,
  input wire logic       first_toggle_oe,
  input wire logic       third_toggle_oe
);
  import rct_pkg::*;
  logic [7:0] wdata_q;  // Write data one cycle late.
  logic       cfg0_q;   // Config write to the first channel, one cycle late.
  logic       tog_q;    // Toggle level last written to the first channel.
  wire logic  cfg0   = sfr_wr_en && sfr_page == 8'h00 && sfr_addr == OFS_TIMER_CONFIGURATION;
  wire logic  rd_cfg = sfr_rd_en && sfr_page <= 8'h02 && sfr_addr == OFS_TIMER_CONFIGURATION;
  wire logic  rd_ctl = sfr_rd_en && sfr_page <= 8'h02 && sfr_addr == OFS_TIMER_CONTROL;
  // Delayed copies of the last write.
  always_ff @(posedge clk) begin
    wdata_q <= sfr_wdata;
    cfg0_q  <= cfg0;
    tog_q   <= cfg0 ? sfr_wdata[CFG_TOGGLE_STATE] : tog_q;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence cfg_wr_first;
    cfg0;
  endsequence
  sequence cfg_wr_third;
    sfr_wr_en && sfr_page == 8'h02 && sfr_addr == OFS_TIMER_CONFIGURATION;
  endsequence
  a_rdata_idle: assert property (!sfr_rd_en |=> sfr_rdata == READ_IDLE)
    else $error("read data not idle between reads");
  a_page_unmapped: assert property (sfr_rd_en && sfr_page > 8'h02 |=> sfr_rdata == READ_IDLE)
    else $error("unmapped page read not zero");
  a_addr_unmapped: assert property (sfr_rd_en && (sfr_addr < OFS_TIMER_CONTROL ||
    sfr_addr > OFS_COUNTER_HIGH_BYTE) |=> sfr_rdata == READ_IDLE) else $error("unmapped offset read not zero");
  a_ctl_reserved: assert property (rd_ctl |=> sfr_rdata[5:4] == 2'b00)
    else $error("control reserved bits not zero");
  a_cfg_reserved: assert property (rd_cfg |=> sfr_rdata[7:5] == 3'b000)
    else $error("config reserved bits not zero");
  a_second_no_toggle: assert property (rd_cfg && sfr_page == 8'h01 |=> sfr_rdata[2:1] == 2'b00)
    else $error("second channel shows toggle bits");
  a_oe_first: assert property (cfg_wr_first |=> first_toggle_oe == wdata_q[CFG_TOGGLE_OUTPUT_EN])
    else $error("first enable pin not following write");
  a_oe_third: assert property (cfg_wr_third |=> third_toggle_oe == wdata_q[CFG_TOGGLE_OUTPUT_EN])
    else $error("third enable pin not following write");
  a_oe_steady: assert property ($changed(first_toggle_oe) |-> cfg0_q)
    else $error("first enable pin moved without a write");
  a_toggle_forced: assert property (cfg_wr_first |=> ##[0:1] first_toggle_out == tog_q)
    else $error("toggle pin not forced to written level");
endmodule

bind rct_timer_top rct_timer_top_asserts u_rct_timer_top_asserts (.*);

/* File: bench/rct_pin_model.sv */
`timescale 1ns/1ns
// Oscillator plus count and gate pins; pins idle high, as with a pull-up.
module rct_pin_model (
  input  wire logic clk,
  output logic      ext_clock        = 1'b0,
  output logic      shared_count_pin = 1'b1,
  output logic      third_count_pin  = 1'b1,
  output logic      shared_gate_pin  = 1'b1,
  output logic      third_gate_pin   = 1'b1
);
  // Three system periods: below half the system rate.
  always #75 ext_clock = ~ext_clock;
  // Each level stands four cycles, past the synchroniser.
  task automatic set_gate(input logic third, input logic level);
    @(posedge clk);
    if (third)
      third_gate_pin <= level;
    else
      shared_gate_pin <= level;
    repeat (4) @(posedge clk);
  endtask
  // One falling edge, then back to idle.
  task automatic gate_fall(input logic third);
    set_gate(third, 1'b0);
    set_gate(third, 1'b1);
  endtask
  // Falling edges on the shared count pin, each level held three cycles.
  task automatic count_shared(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      shared_count_pin <= 1'b0;
      repeat (3) @(posedge clk);
      shared_count_pin <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule

/* File: bench/tb_rct_timer_top.sv */
`timescale 1ns/1ns
// Drives the register bus and judges pins and read data.
module tb_rct_timer_top;
  import rct_pkg::*;
  logic       clk         = 1'b0;
  logic       reset       = 1'b1;
  logic [7:0] sfr_page    = 8'h00;
  logic [7:0] sfr_addr    = 8'h00;
  logic [7:0] sfr_wdata   = 8'h00;
  logic       sfr_wr_en   = 1'b0;
  logic       sfr_rd_en   = 1'b0;
  logic       sel_third   = 1'b0;  // Picks which toggle pin is measured.
  int         num_errors  = 0;
  int         checks_done = 0;
  wire logic [7:0] sfr_rdata;
  wire logic  ext_clock, shared_count_pin, third_count_pin, shared_gate_pin, third_gate_pin;
  wire logic  first_toggle_out, first_toggle_oe, third_toggle_out, third_toggle_oe;
  wire logic  tog = sel_third ? third_toggle_out : first_toggle_out;
  always #25 clk = ~clk;
  rct_timer_top u_rct_timer_top (.*);
  rct_pin_model u_rct_pin_model (.*);
  // One write strobe; the idle cycle after it keeps strobes one cycle apart.
  task automatic wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_page  <= p;
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr_en <= 1'b1;
    @(posedge clk);
    sfr_wr_en <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe, so it is taken then.
  task automatic rd(input logic [7:0] p, input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_page  <= p;
    sfr_addr  <= a;
    sfr_rd_en <= 1'b1;
    @(posedge clk);
    sfr_rd_en <= 1'b0;
    #1;
    d = sfr_rdata;
  endtask
  // Byte pairs are independent; low first by habit.
  task automatic wr16(input logic [7:0] p, input logic [7:0] a, input logic [15:0] v);
    wr(p, a, v[7:0]);
    wr(p, a + 8'h01, v[15:8]);
  endtask
  task automatic rd16(input logic [7:0] p, input logic [7:0] a, output logic [15:0] v);
    rd(p, a, v[7:0]);
    rd(p, a + 8'h01, v[15:8]);
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chkr(input string name, input int lo, input int hi, input logic [15:0] got);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask
  // Cycles of two half periods, sampled at falling edges where the pin is settled.
  task automatic measure(output logic [15:0] n [2]);
    logic v;
    for (int k = 0; k < 2; k++) begin
      v = tog;
      n[k] = 16'h0000;
      for (int i = 0; i < 400 && tog === v; i++) @(negedge clk);
      v = tog;
      for (int i = 0; i < 400 && tog === v; i++) begin
        @(negedge clk);
        n[k]++;
      end
    end
  endtask
  // Pages 0 to 3 and offsets C8 to CE, mapped or not, read zero.
  task automatic t_reset;
    logic [7:0] d;
    for (int p = 0; p < 4; p++) begin
      for (int a = 8'hC8; a <= 8'hCE; a++) begin
        rd(p[7:0], a[7:0], d);
        chk("reset read", 16'h0, {8'h00, d});
      end
    end
    $display("test reset done");
  endtask
  task automatic t_counter;
    logic [15:0] v;
    wr16(8'h00, OFS_COUNTER_LOW_BYTE, 16'h0000);
    wr(8'h00, OFS_TIMER_CONTROL, 8'h06);
    u_rct_pin_model.count_shared(3);
    repeat (4) @(posedge clk);
    wr(8'h00, OFS_TIMER_CONTROL, 8'h00);
    rd16(8'h00, OFS_COUNTER_LOW_BYTE, v);
    chk("pin count", 16'h0003, v);
    $display("test counter done");
  endtask
  // One overflow only: the reload value is far below the wrap point.
  task automatic t_up;
    logic [7:0]  d;
    logic [15:0] v;
    logic [15:0] w;
    wr16(8'h00, OFS_RELOAD_CAPTURE_LOW, 16'h1000);
    wr16(8'h00, OFS_COUNTER_LOW_BYTE, 16'hFFFE);
    wr(8'h00, OFS_TIMER_CONFIGURATION, 8'h08);
    wr(8'h00, OFS_TIMER_CONTROL, 8'h04);
    repeat (8) @(posedge clk);
    rd(8'h00, OFS_TIMER_CONTROL, d);
    chk("up flags", 16'h00C4, {8'h00, d});
    rd(8'h00, OFS_COUNTER_HIGH_BYTE, d);
    chk("up reload", 16'h0010, {8'h00, d});
    wr(8'h00, OFS_TIMER_CONTROL, 8'h00);
    rd16(8'h00, OFS_COUNTER_LOW_BYTE, v);
    repeat (10) @(posedge clk);
    rd16(8'h00, OFS_COUNTER_LOW_BYTE, w);
    chk("halted count", v, w);
    $display("test up reload done");
  endtask
  // A low gate level with down counting enabled makes the counter fall.
  task automatic t_down;
    logic [7:0] d;
    u_rct_pin_model.set_gate(1'b0, 1'b0);
    wr16(8'h00, OFS_RELOAD_CAPTURE_LOW, 16'h0100);
    wr16(8'h00, OFS_COUNTER_LOW_BYTE, 16'h0104);
    wr(8'h00, OFS_TIMER_CONFIGURATION, 8'h09);
    wr(8'h00, OFS_TIMER_CONTROL, 8'h04);
    repeat (10) @(posedge clk);
    rd(8'h00, OFS_TIMER_CONTROL, d);
    chk("down flags", 16'h00C4, {8'h00, d});
    rd(8'h00, OFS_COUNTER_HIGH_BYTE, d);
    chk("down reload", 16'h00FF, {8'h00, d});
    wr(8'h00, OFS_TIMER_CONTROL, 8'h00);
    wr(8'h00, OFS_TIMER_CONFIGURATION, 8'h00);
    u_rct_pin_model.set_gate(1'b0, 1'b1);
    $display("test down reload done");
  endtask
  // Timers stand still so that captured and reloaded values are exact.
  task automatic t_gate;
    logic [7:0]  d;
    logic [15:0] v;
    wr16(8'h00, OFS_COUNTER_LOW_BYTE, 16'h1234);
    wr(8'h00, OFS_TIMER_CONTROL, 8'h01);
    wr16(8'h01, OFS_RELOAD_CAPTURE_LOW, 16'h4321);
    wr16(8'h01, OFS_COUNTER_LOW_BYTE, 16'h0005);
    wr(8'h01, OFS_TIMER_CONTROL, 8'h08);
    wr16(8'h02, OFS_COUNTER_LOW_BYTE, 16'h7777);
    wr(8'h02, OFS_TIMER_CONTROL, 8'h09);
    u_rct_pin_model.gate_fall(1'b0);
    rd16(8'h00, OFS_RELOAD_CAPTURE_LOW, v);
    chk("disabled capture", 16'h0100, v);
    rd16(8'h01, OFS_COUNTER_LOW_BYTE, v);
    chk("gate reload", 16'h4321, v);
    rd(8'h01, OFS_TIMER_CONTROL, d);
    chk("reload flag", 16'h0048, {8'h00, d});
    rd16(8'h02, OFS_RELOAD_CAPTURE_LOW, v);
    chk("third untouched", 16'h0000, v);
    wr(8'h00, OFS_TIMER_CONTROL, 8'h09);
    u_rct_pin_model.gate_fall(1'b0);
    rd16(8'h00, OFS_RELOAD_CAPTURE_LOW, v);
    chk("capture value", 16'h1234, v);
    rd(8'h00, OFS_TIMER_CONTROL, d);
    chk("capture flag", 16'h0049, {8'h00, d});
    u_rct_pin_model.gate_fall(1'b1);
    rd16(8'h02, OFS_RELOAD_CAPTURE_LOW, v);
    chk("third capture", 16'h7777, v);
    wr(8'h00, OFS_TIMER_CONTROL, 8'h09);
    rd(8'h00, OFS_TIMER_CONTROL, d);
    chk("flag cleared", 16'h0009, {8'h00, d});
    for (int p = 0; p < 3; p++) wr(p[7:0], OFS_TIMER_CONTROL, 8'h00);
    $display("test gate done");
  endtask
  // Reload two below the wrap, so each half period is two timer clocks.
  task automatic t_toggle;
    logic [1:0]  sel [4] = '{CLK_SYS_DIV12, CLK_SYS, CLK_EXT_DIV8, CLK_SYS_DIV2};
    int          lo [4]  = '{24, 2, 47, 4};
    int          hi [4]  = '{24, 2, 49, 4};
    logic [15:0] n [2];
    logic [7:0]  pg;
    logic [7:0]  d;
    for (int i = 0; i < 4; i++) begin
      pg = (i == 3) ? 8'h02 : 8'h00;
      sel_third = (i == 3);
      wr16(pg, OFS_RELOAD_CAPTURE_LOW, 16'hFFFE);
      wr16(pg, OFS_COUNTER_LOW_BYTE, 16'hFFFE);
      wr(pg, OFS_TIMER_CONFIGURATION, {3'b000, sel[i], 3'b010});
      wr(pg, OFS_TIMER_CONTROL, 8'h04);
      measure(n);
      chkr("half period one", lo[i], hi[i], n[0]);
      chkr("half period two", lo[i], hi[i], n[1]);
      wr(pg, OFS_TIMER_CONTROL, 8'h00);
    end
    wr(8'h00, OFS_TIMER_CONFIGURATION, 8'h06);
    repeat (2) @(posedge clk);
    chk("forced high", 16'h1, {15'h0, first_toggle_out});
    chk("pin enabled", 16'h1, {15'h0, first_toggle_oe});
    rd(8'h00, OFS_TIMER_CONFIGURATION, d);
    chk("toggle readback", 16'h0006, {8'h00, d});
    wr(8'h00, OFS_TIMER_CONFIGURATION, 8'h00);
    repeat (2) @(posedge clk);
    chk("forced low", 16'h0, {15'h0, first_toggle_out});
    chk("pin released", 16'h0, {15'h0, first_toggle_oe});
    $display("test toggle done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_counter();
    t_up();
    t_down();
    t_gate();
    t_toggle();
    summarize();
  end
  // Tests take well under a thousand cycles.
  initial begin
    #1000000;
    num_errors++;
    summarize();
  end
endmodule
